// ### logic/pss_pkg.sv
// Constants and types shared by the supply supervisor design
package pss_pkg;
   // ------------------------------------------------------------------
   // Time base
   // ------------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1_000;
   localparam int QW = 24;

   // ------------------------------------------------------------------
   // Qualification and delay times, in their own units
   // ------------------------------------------------------------------
   localparam int T_OVP_US = 50;
   localparam int T_ACF_US = 200;
   localparam int T_UVP_MS_X10 = 24;
   localparam int T_OPP_MS = 7;
   localparam int T_NVP_MS = 7;
   localparam int T_PG_MS = 300;
   localparam int T_PSOFF_MS = 2;
   localparam int PWM_HZ = 65_000;
   localparam int DUTY_MAX_PCT = 93;
   localparam int DUTY_MIN_PCT = 85;

   // ------------------------------------------------------------------
   // Derived cycle counts
   // ------------------------------------------------------------------
   localparam int OVP_CYC = T_OVP_US * CYC_PER_US;
   localparam int ACF_CYC = T_ACF_US * CYC_PER_US;
   localparam int UVP_CYC = T_UVP_MS_X10 * CYC_PER_MS / 10;
   localparam int OPP_CYC = T_OPP_MS * CYC_PER_MS;
   localparam int NVP_CYC = T_NVP_MS * CYC_PER_MS;
   localparam int PG_CYC = T_PG_MS * CYC_PER_MS;
   localparam int PSOFF_CYC = T_PSOFF_MS * CYC_PER_MS;
   localparam int PWM_PER = CLK_HZ / PWM_HZ;
   localparam int PWM_MAX_ON = PWM_PER * DUTY_MAX_PCT / 100;
   localparam logic [8:0] PWM_LAST = 9'(PWM_PER - 1);
   localparam logic [8:0] PWM_ON_LAST = 9'(PWM_MAX_ON - 1);

   // ------------------------------------------------------------------
   // Qualification channels
   // ------------------------------------------------------------------
   localparam int CH_ACF = 0;
   localparam int CH_OPP = 1;
   localparam int CH_NVP = 2;
   localparam int CH_OVP = 3;
   localparam int CH_UVP = 6;
   localparam int NCH = 9;

   // ------------------------------------------------------------------
   // Synchronised input vector layout
   // ------------------------------------------------------------------
   localparam int IN_GOOD = 0;
   localparam int IN_UVP = 3;
   localparam int IN_OVP = 6;
   localparam int IN_NVP = 9;
   localparam int IN_OPP = 10;
   localparam int IN_ACF = 11;
   localparam int IN_REQ_OFF = 12;
   localparam int IN_STOP = 13;
   localparam int IN_VCC_OV = 14;
   localparam int IN_W = 15;
   localparam logic [14:0] IN_RST = 15'h1000;

   // ------------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_OFF   = 6'h01,
      ST_RAMP  = 6'h02,
      ST_GOOD  = 6'h04,
      ST_LOCK  = 6'h08,
      ST_PSOFF = 6'h10,
      ST_FAULT = 6'h20
   } pss_state_t;
endpackage : pss_pkg

// ### logic/pss_qual_if.sv
// Link between the sequencer and one fault qualification timer
`timescale 1ns/1ps
interface pss_qual_if (
   input wire logic clk,
   input wire logic rst_n
);
   logic flag;
   logic arm;
   logic hit;
   modport timer (input clk, input rst_n, input flag, input arm, output hit);
   modport ctrl (output flag, output arm, input hit);
endinterface : pss_qual_if

// ### logic/pss_qual_timer.sv
// Fault qualification timer: flags a fault held for a full interval
`timescale 1ns/1ps
module pss_qual_timer #(
   parameter int LIM = 1
) (
   pss_qual_if.timer q
);
   localparam logic [pss_pkg::QW-1:0] LIM_V = pss_pkg::QW'(LIM);

   logic [pss_pkg::QW-1:0] cnt_ff;

   // Count while the flag holds, restart on any drop, saturate at limit
   always_ff @(posedge q.clk or negedge q.rst_n) begin
      if (!q.rst_n) begin
         cnt_ff <= '0;
      end else if (!q.arm || !q.flag) begin
         cnt_ff <= '0;
      end else if (cnt_ff != LIM_V) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // Qualified once the interval has run out
   assign q.hit = (cnt_ff == LIM_V);

   a_qual_restart: assert property (@(posedge q.clk) disable iff (!q.rst_n)
      !(q.flag && q.arm) |=> (cnt_ff == '0) && !q.hit)
      else $error("qualification count did not restart");
   a_qual_hit_time: assert property (@(posedge q.clk) disable iff (!q.rst_n)
      $rose(q.hit) |-> $past(q.flag && q.arm))
      else $error("qualified without a held flag");
endmodule : pss_qual_timer

// ### logic/pss_supervisor.sv
// Supply supervisor: fault qualification, power-good sequencing, PWM drive
`timescale 1ns/1ps
module pss_supervisor #(
   parameter int UVP_CYC = pss_pkg::UVP_CYC,
   parameter int OPP_CYC = pss_pkg::OPP_CYC,
   parameter int NVP_CYC = pss_pkg::NVP_CYC,
   parameter int PG_CYC = pss_pkg::PG_CYC,
   parameter int PSOFF_CYC = pss_pkg::PSOFF_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic remote_off_req_i,
   input wire logic [2:0] rail_good_i,
   input wire logic [2:0] rail_undervolt_protect_i,
   input wire logic [2:0] rail_overvolt_protect_i,
   input wire logic negative_rail_sense_i,
   input wire logic overload_sum_level_i,
   input wire logic ac_low_i,
   input wire logic pwm_stop_i,
   input wire logic vcc_overvolt_i,
   output logic supply_good_out_o,
   output logic supply_good_oe_o,
   output logic drive_out_a_o,
   output logic drive_out_b_o,
   output logic power_on_o,
   output logic fault_latched_o
);
   localparam logic [pss_pkg::QW-1:0] PG_LAST = pss_pkg::QW'(PG_CYC - 1);
   localparam logic [pss_pkg::QW-1:0] PSOFF_LAST = pss_pkg::QW'(PSOFF_CYC - 1);
   localparam int QLIM [pss_pkg::NCH] = '{pss_pkg::ACF_CYC, OPP_CYC, NVP_CYC,
      pss_pkg::OVP_CYC, pss_pkg::OVP_CYC, pss_pkg::OVP_CYC, UVP_CYC, UVP_CYC, UVP_CYC};

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   logic [pss_pkg::IN_W-1:0] raw_in;
   logic [pss_pkg::IN_W-1:0] sync1_ff;
   logic [pss_pkg::IN_W-1:0] sync2_ff;

   assign raw_in = {vcc_overvolt_i, pwm_stop_i, remote_off_req_i, ac_low_i,
      overload_sum_level_i, negative_rail_sense_i, rail_overvolt_protect_i,
      rail_undervolt_protect_i, rail_good_i};

   // Two flops on every pin
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_ff <= pss_pkg::IN_RST;
         sync2_ff <= pss_pkg::IN_RST;
      end else begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
      end
   end

   logic vcc_ov;
   logic req_off;
   logic rails_ok;
   logic stop;
   assign vcc_ov = sync2_ff[pss_pkg::IN_VCC_OV];
   assign req_off = sync2_ff[pss_pkg::IN_REQ_OFF];
   assign rails_ok = &sync2_ff[pss_pkg::IN_GOOD +: 3];
   assign stop = sync2_ff[pss_pkg::IN_STOP];

   // ------------------------------------------------------------------
   // Fault qualification timers
   // ------------------------------------------------------------------
   pss_pkg::pss_state_t state_ff;
   pss_pkg::pss_state_t nxt_state;
   logic power_on_ff;
   logic [pss_pkg::NCH-1:0] flag_v;
   logic [pss_pkg::NCH-1:0] arm_v;
   logic [pss_pkg::NCH-1:0] hit_v;

   assign flag_v = {sync2_ff[pss_pkg::IN_UVP +: 3], sync2_ff[pss_pkg::IN_OVP +: 3],
      sync2_ff[pss_pkg::IN_NVP], sync2_ff[pss_pkg::IN_OPP], sync2_ff[pss_pkg::IN_ACF]};

   // Under-voltage is armed only once the sequencer has left the ramp state
   always_comb begin
      arm_v = {pss_pkg::NCH{power_on_ff && !vcc_ov}};
      if (state_ff == pss_pkg::ST_RAMP) begin
         arm_v[pss_pkg::CH_UVP +: 3] = 3'h0;
      end
   end

   pss_qual_if qif [pss_pkg::NCH] (.clk(clk_i), .rst_n(rst_n_i));

   // One timer per channel, each rail on its own
   generate
      for (genvar g = 0; g < pss_pkg::NCH; g++) begin : g_qual
         assign qif[g].flag = flag_v[g];
         assign qif[g].arm = arm_v[g];
         assign hit_v[g] = qif[g].hit;
         pss_qual_timer #(.LIM(QLIM[g])) u_tmr (.q(qif[g]));
      end
   endgenerate

   logic fault_any;
   logic ac_fail;
   // Qualified faults that lock the outputs off; AC fail only locks power-good low
   assign fault_any = |hit_v[pss_pkg::NCH-1:pss_pkg::CH_OPP];
   assign ac_fail = hit_v[pss_pkg::CH_ACF];

   // ------------------------------------------------------------------
   // Power sequencer
   // ------------------------------------------------------------------
   logic [pss_pkg::QW-1:0] tmr_ff;
   logic [pss_pkg::QW-1:0] nxt_tmr;

   // Next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         pss_pkg::ST_OFF: begin
            if (!req_off) nxt_state = pss_pkg::ST_RAMP;
         end
         pss_pkg::ST_RAMP: begin
            if (fault_any) nxt_state = pss_pkg::ST_FAULT;
            else if (req_off) nxt_state = pss_pkg::ST_PSOFF;
            else if (rails_ok && tmr_ff == PG_LAST) nxt_state = pss_pkg::ST_GOOD;
         end
         pss_pkg::ST_GOOD: begin
            if (fault_any) nxt_state = pss_pkg::ST_FAULT;
            else if (req_off) nxt_state = pss_pkg::ST_PSOFF;
            else if (!rails_ok || ac_fail) nxt_state = pss_pkg::ST_LOCK;
         end
         pss_pkg::ST_LOCK: begin
            if (fault_any) nxt_state = pss_pkg::ST_FAULT;
            else if (req_off) nxt_state = pss_pkg::ST_PSOFF;
         end
         pss_pkg::ST_PSOFF: begin
            if (fault_any) nxt_state = pss_pkg::ST_FAULT;
            else if (tmr_ff == PSOFF_LAST) nxt_state = pss_pkg::ST_OFF;
         end
         pss_pkg::ST_FAULT: begin
            if (req_off) nxt_state = pss_pkg::ST_OFF;
         end
         default: nxt_state = pss_pkg::ST_OFF;
      endcase
   end

   // Delay counter for power-good rise and shutdown wait
   always_comb begin
      if (nxt_state != state_ff) nxt_tmr = '0;
      else if (state_ff == pss_pkg::ST_RAMP && !rails_ok) nxt_tmr = '0;
      else if (state_ff == pss_pkg::ST_RAMP || state_ff == pss_pkg::ST_PSOFF) begin
         nxt_tmr = tmr_ff + 1'b1;
      end else nxt_tmr = '0;
   end

   // Sequencer state and registered outputs, cleared on supply over-voltage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= pss_pkg::ST_OFF;
         tmr_ff <= '0;
         power_on_ff <= 1'b0;
         supply_good_out_o <= 1'b0;
         supply_good_oe_o <= 1'b1;
         fault_latched_o <= 1'b0;
      end else if (vcc_ov) begin
         state_ff <= pss_pkg::ST_OFF;
         tmr_ff <= '0;
         power_on_ff <= 1'b0;
         supply_good_out_o <= 1'b0;
         supply_good_oe_o <= 1'b1;
         fault_latched_o <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         tmr_ff <= nxt_tmr;
         power_on_ff <= !(nxt_state inside {pss_pkg::ST_OFF, pss_pkg::ST_FAULT});
         supply_good_out_o <= (nxt_state == pss_pkg::ST_GOOD);
         supply_good_oe_o <= (nxt_state != pss_pkg::ST_GOOD);
         fault_latched_o <= (nxt_state == pss_pkg::ST_FAULT);
      end
   end
   assign power_on_o = power_on_ff;

   // ------------------------------------------------------------------
   // PWM stage
   // ------------------------------------------------------------------
   logic [8:0] pwm_cnt_ff;
   logic phase_ff;
   logic on_ff;
   logic nxt_on;
   logic nxt_phase;
   logic wrap;

   assign wrap = (pwm_cnt_ff == pss_pkg::PWM_LAST);
   assign nxt_phase = wrap ? !phase_ff : phase_ff;

   // Pulse starts each period, ends on the comparator or the duty cap
   always_comb begin
      if (wrap) nxt_on = power_on_ff;
      else nxt_on = on_ff && !stop && (pwm_cnt_ff < pss_pkg::PWM_ON_LAST);
   end

   // Period counter and steered drive outputs
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwm_cnt_ff <= '0;
         phase_ff <= 1'b0;
         on_ff <= 1'b0;
         drive_out_a_o <= 1'b0;
         drive_out_b_o <= 1'b0;
      end else if (vcc_ov || !power_on_ff) begin
         pwm_cnt_ff <= '0;
         phase_ff <= 1'b0;
         on_ff <= 1'b0;
         drive_out_a_o <= 1'b0;
         drive_out_b_o <= 1'b0;
      end else begin
         pwm_cnt_ff <= wrap ? 9'h000 : pwm_cnt_ff + 9'h001;
         phase_ff <= nxt_phase;
         on_ff <= nxt_on;
         drive_out_a_o <= nxt_on && !nxt_phase;
         drive_out_b_o <= nxt_on && nxt_phase;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   logic [8:0] run_a_ff;
   logic [pss_pkg::QW-1:0] good_run_ff;

   // Helper counters: on-time of output A, consecutive good-rail cycles
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_a_ff <= '0;
         good_run_ff <= '0;
      end else begin
         run_a_ff <= drive_out_a_o ? run_a_ff + 9'h001 : 9'h000;
         good_run_ff <= rails_ok ? good_run_ff + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i || vcc_ov);

   sequence s_opp_trip;
      hit_v[pss_pkg::CH_OPP] && power_on_ff;
   endsequence
   sequence s_nvp_trip;
      hit_v[pss_pkg::CH_NVP] && power_on_ff;
   endsequence
   sequence s_latched_off;
      (state_ff == pss_pkg::ST_FAULT) ##0 (!supply_good_out_o && !power_on_ff);
   endsequence

   a_opp_latch: assert property (s_opp_trip |=> s_latched_off)
      else $error("over-power did not latch off");
   a_nvp_latch: assert property (s_nvp_trip |=> s_latched_off)
      else $error("negative rail fault did not latch off");
   a_duty_cap: assert property (run_a_ff <= 9'(pss_pkg::PWM_MAX_ON))
      else $error("drive A exceeded max duty");
   a_drive_exclusive: assert property (!(drive_out_a_o && drive_out_b_o))
      else $error("both drive outputs on");
   a_pg_rails: assert property ($fell(rails_ok) |-> ##[1:2] !supply_good_out_o)
      else $error("power-good high with rails bad");
   a_pg_delay: assert property ($rose(supply_good_out_o) |-> good_run_ff >= PG_LAST)
      else $error("power-good rose before delay");
   a_pg_lockup: assert property ($fell(supply_good_out_o) |-> !supply_good_out_o [*8])
      else $error("power-good recovered by itself");
   a_psoff_wait: assert property ($fell(power_on_ff) |->
      $past(fault_any) || $past(tmr_ff) == PSOFF_LAST)
      else $error("outputs off before shutdown delay");
   a_fault_hold: assert property (state_ff == pss_pkg::ST_FAULT && !req_off
      |=> state_ff == pss_pkg::ST_FAULT)
      else $error("latched fault cleared without remote off");
   a_remote_off: assert property (state_ff == pss_pkg::ST_OFF && req_off
      |=> state_ff == pss_pkg::ST_OFF && !power_on_ff)
      else $error("outputs on while remote requests off");
endmodule : pss_supervisor

// ### testbench/pss_host_model.sv
// Motherboard model: drives the remote on/off request and reads power-good
`timescale 1ns/1ps
module pss_host_model (
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic supply_good_oe_i,
   output logic remote_off_req_o,
   output logic pg_seen_o
);
   // Remote request starts in the shut-down level
   initial remote_off_req_o = 1'b1;

   // Low asks for operation, high asks for shut-down
   always @(posedge clk_i) begin
      remote_off_req_o <= #2 !run_i;
   end

   // Open-collector line with a pull-up on the board
   assign pg_seen_o = supply_good_oe_i ? 1'b0 : 1'b1;
endmodule : pss_host_model

// ### testbench/psu_supervisor_fault_timer_tb_top.sv
// Self-checking testbench of the supply supervisor
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module psu_supervisor_fault_timer_tb_top;
   // ------------------------------------------------------------------
   // Shortened counts and stimulus
   // ------------------------------------------------------------------
   localparam int UVP_L = 20;
   localparam int OPP_L = 30;
   localparam int NVP_L = 30;
   localparam int PG_L = 50;
   localparam int OFF_L = 20;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic run = 1'b0;
   logic [2:0] rail_good = 3'h0;
   logic [7:0] flt = 8'h00;
   logic ac_low = 1'b0;
   logic pwm_stop = 1'b0;
   logic vcc_ov = 1'b0;
   logic remote, pg_seen, good, oe, da, db, on, fault;
   logic pa = 1'b0;
   logic pb = 1'b0;
   int num_errors = 0;
   int n_compared = 0;
   int lims[8];
   int cyc = 0;
   int last_st = 0;
   int side = -1;
   int ont = 0;

   always #25 clk_i = ~clk_i;

   pss_supervisor #(.UVP_CYC(UVP_L), .OPP_CYC(OPP_L), .NVP_CYC(NVP_L), .PG_CYC(PG_L),
      .PSOFF_CYC(OFF_L)) dut_u (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .remote_off_req_i(remote),
      .rail_good_i(rail_good), .rail_undervolt_protect_i(flt[7:5]),
      .rail_overvolt_protect_i(flt[4:2]), .negative_rail_sense_i(flt[1]),
      .overload_sum_level_i(flt[0]), .ac_low_i(ac_low), .pwm_stop_i(pwm_stop),
      .vcc_overvolt_i(vcc_ov), .supply_good_out_o(good), .supply_good_oe_o(oe),
      .drive_out_a_o(da), .drive_out_b_o(db), .power_on_o(on), .fault_latched_o(fault));

   pss_host_model host_u (.clk_i(clk_i), .run_i(run), .supply_good_oe_i(oe),
      .remote_off_req_o(remote), .pg_seen_o(pg_seen));

   // Random pulse terminations from the current comparator
   always @(posedge clk_i) begin
      #2;
      pwm_stop <= ($urandom % 97 == 0);
   end

   // PWM watch: overlap, alternation, period and on-time
   always @(posedge clk_i) begin
      #1;
      cyc++;
      if (!on) side = -1;
      `CHK(da & db, 1'b0)
      if ((da & !pa) | (db & !pb)) begin
         if (side >= 0 && cyc - last_st == pss_pkg::PWM_PER) `CHK(da, side == 1)
         if (side >= 0) `CHK((cyc - last_st) % pss_pkg::PWM_PER, 0)
         side = db;
         last_st = cyc;
      end
      ont = (da | db) ? ont + 1 : 0;
      `CHK(ont <= pss_pkg::PWM_MAX_ON, 1'b1)
      pa = da;
      pb = db;
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic summarize();
      if (num_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   task automatic tick(int n);
      repeat (n) begin
         @(posedge clk_i);
         #2;
      end
   endtask : tick

   function automatic logic pick(int k);
      case (k)
         0: return on;
         1: return good;
         default: return fault;
      endcase
   endfunction : pick

   // Bounded wait for an output level
   task automatic wait_out(int k, logic v, int bound);
      int i;
      i = 0;
      while (pick(k) !== v && i < bound) begin
         tick(1);
         i++;
      end
      if (pick(k) !== v) begin
         num_errors++;
         summarize();
      end
   endtask : wait_out

   task automatic go_good();
      run = 1'b1;
      wait_out(0, 1'b1, 6);
      tick(PG_L - 4);
      `CHK(good, 1'b0)
      wait_out(1, 1'b1, 10);
      `CHK(pg_seen, 1'b1)
      `CHK(oe, 1'b0)
   endtask : go_good

   task automatic go_off();
      run = 1'b0;
      wait_out(1, 1'b0, 6);
      `CHK(oe, 1'b1)
      tick(OFF_L - 4);
      `CHK(on, 1'b1)
      wait_out(0, 1'b0, 8);
      tick(4);
      `CHK(da | db, 1'b0)
   endtask : go_off

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      void'($urandom(32'h7d2103ea));
      lims = '{OPP_L, NVP_L, pss_pkg::OVP_CYC, pss_pkg::OVP_CYC, pss_pkg::OVP_CYC,
               UVP_L, UVP_L, UVP_L};
      tick(8);
      rst_n_i = 1'b1;
      tick(2);
      `CHK({on, good, fault, da, db, oe}, 6'h01)
      rail_good = 3'h7;
      go_good();
      go_off();
      // Loss of each rail locks power-good low
      for (int k = 0; k < 3; k++) begin
         go_good();
         rail_good[k] = 1'b0;
         wait_out(1, 1'b0, 8);
         `CHK(pg_seen, 1'b0)
         rail_good[k] = 1'b1;
         tick(20);
         `CHK(good, 1'b0)
         `CHK(on, 1'b1)
         go_off();
      end
      // Each protection flag: early drop, then full qualification
      for (int c = 0; c < 8; c++) begin
         go_good();
         flt[c] = 1'b1;
         tick(lims[c] - 4 + int'($urandom % 2));
         flt[c] = 1'b0;
         tick(3);
         flt[c] = 1'b1;
         tick(lims[c]);
         `CHK(fault, 1'b0)
         wait_out(2, 1'b1, 8);
         tick(1);
         `CHK({on, good}, 2'b00)
         flt[c] = 1'b0;
         tick(5);
         `CHK(fault, 1'b1)
         run = 1'b0;
         wait_out(2, 1'b0, 8);
         `CHK(on, 1'b0)
      end
      // AC line failure warning
      go_good();
      ac_low = 1'b1;
      tick(pss_pkg::ACF_CYC - 500);
      ac_low = 1'b0;
      tick(3);
      `CHK(good, 1'b1)
      ac_low = 1'b1;
      tick(pss_pkg::ACF_CYC);
      `CHK(good, 1'b1)
      wait_out(1, 1'b0, 8);
      `CHK(on, 1'b1)
      ac_low = 1'b0;
      tick(20);
      `CHK(good, 1'b0)
      go_off();
      // Supply over-voltage clears everything
      go_good();
      vcc_ov = 1'b1;
      tick(4);
      `CHK({on, good, fault, da, db, oe}, 6'h01)
      run = 1'b0;
      tick(4);
      vcc_ov = 1'b0;
      tick(4);
      `CHK(on, 1'b0)
      summarize();
   end
endmodule : psu_supervisor_fault_timer_tb_top
